// ---- hdl/ecp_defs.svh ----
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH
`define ECP_CLK_PERIOD_NS 40
`define ECP_TCY_NS 160
`define ECP_CLK_PER_TCY (`ECP_TCY_NS / `ECP_CLK_PERIOD_NS)
`define ECP_CFG_MSB 7
`define ECP_CFG_LSB 6
`define ECP_DUTY_LO_MSB 5
`define ECP_DUTY_LO_LSB 4
`define ECP_MODE_MSB 3
`define ECP_MODE_LSB 0
`define ECP_MODE_PWM 2'h3
`define ECP_MODE_CMP 2'h2
`define ECP_MODE_TRIG 4'hb
`define ECP_CFG_SINGLE 2'h0
`define ECP_CFG_HALF 2'h2
`define ECP_CFG_FWD 2'h1
`define ECP_CFG_REV 2'h3
`define ECP_PS_DIV1 2'h0
`define ECP_PS_DIV4 2'h1
`define ECP_RST_DUTY 10'h000
`define ECP_RST_DELAY 7'h00
`endif

// ---- hdl/ecp_pkg.sv ----
package ecp_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'h1,
      st_wait = 3'h2,
      st_run = 3'h4
   } ecp_state_t;
   typedef struct packed {
      logic [1:0] q;
      logic [3:0] pre;
      logic [7:0] tmr;
      logic period_start;
   } ecp_tb_state_t;
   typedef struct packed {
      logic [1:0][8:0] cnt;
      logic [1:0] prev;
      logic [1:0] out;
   } ecp_db_state_t;
   typedef struct packed {
      ecp_state_t st;
      logic [1:0] rs1;
      logic [1:0] rs2;
      logic [1:0] cfg;
      logic [1:0] pol;
      logic tsel;
      logic [9:0] duty;
      logic [6:0] dly;
      logic pwm_on;
      logic match_prev;
      logic [3:0] outs;
      logic plain_pin;
      logic cmp_flag;
      logic clr_first;
      logic clr_second;
      logic adc_start;
   } ecp_top_state_t;
endpackage: ecp_pkg

// ---- hdl/ecp_if.sv ----
`timescale 1ns/100ps
interface ecp_tb_if;
   logic [7:0] period;
   logic [1:0] prescale;
   logic [7:0] tmr;
   logic [1:0] fine;
   logic period_start;
   modport tb (input period, input prescale, output tmr, output fine, output period_start);
   modport user (output period, output prescale, input tmr, input fine, input period_start);
endinterface: ecp_tb_if

interface ecp_db_if;
   logic level;
   logic [6:0] delay;
   logic out_a;
   logic out_b;
   modport db (input level, input delay, output out_a, output out_b);
   modport user (output level, output delay, input out_a, input out_b);
endinterface: ecp_db_if

// ---- hdl/ecp_timebase.sv ----
`timescale 1ns/100ps
`include "ecp_defs.svh"
module ecp_timebase (
   input wire logic clk_i,
   input wire logic rst_i,
   ecp_tb_if.tb tb
);
   ecp_pkg::ecp_tb_state_t s;
   ecp_pkg::ecp_tb_state_t next_s;
   logic q_last;
   logic pre_last;

   // No postscaler here: it never shapes the period
   always_comb
   begin
      next_s = s;
      q_last = (s.q == 2'(`ECP_CLK_PER_TCY - 1));
      case (tb.prescale)
         `ECP_PS_DIV1: pre_last = 1'b1;
         `ECP_PS_DIV4: pre_last = (s.pre[1:0] == 2'h3);
         default: pre_last = (s.pre == 4'hf);
      endcase
      next_s.q = s.q + 2'h1;
      next_s.period_start = 1'b0;
      if (q_last)
      begin
         next_s.pre = pre_last ? 4'h0 : s.pre + 4'h1;
         if (pre_last)
         begin
            next_s.period_start = (s.tmr == tb.period);
            next_s.tmr = next_s.period_start ? 8'h00 : s.tmr + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         s <= '0;
      else
         s <= next_s;
   end

   assign tb.tmr = s.tmr;
   assign tb.period_start = s.period_start;
   // Quarter phase at prescale 1, prescaler bits otherwise
   assign tb.fine = (tb.prescale == `ECP_PS_DIV1) ? s.q :
      (tb.prescale == `ECP_PS_DIV4) ? s.pre[1:0] : s.pre[3:2];
endmodule: ecp_timebase

// ---- hdl/ecp_deadband.sv ----
`timescale 1ns/100ps
module ecp_deadband (
   input wire logic clk_i,
   input wire logic rst_i,
   ecp_db_if.db db
);
   ecp_pkg::ecp_db_state_t s;
   ecp_pkg::ecp_db_state_t next_s;
   logic [1:0] src;
   logic [8:0] load;

   // Channel 0 follows the level, channel 1 its complement
   always_comb
   begin
      next_s = s;
      load = {db.delay, 2'h0};
      src = {~db.level, db.level};
      for (int i = 0; i < 2; i++)
      begin
         next_s.prev[i] = src[i];
         if (src[i] && !s.prev[i])
            next_s.cnt[i] = load;
         else if (s.cnt[i] != 9'h000)
            next_s.cnt[i] = s.cnt[i] - 9'h001;
         // Falling before the count ends leaves it off all cycle
         next_s.out[i] = src[i] && (next_s.cnt[i] == 9'h000);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         s <= '0;
      else
         s <= next_s;
   end

   assign db.out_a = s.out[0];
   assign db.out_b = s.out[1];
endmodule: ecp_deadband

// ---- hdl/ecp_top.sv ----
// Functional notes
// - Compare uses first/second compare timer; PWM uses one of two PWM timers.
// - Trigger compare mode pulses a hardware trigger on compare equal timer.
// - Units one and two clear the selected compare timer on trigger.
// - Unit two trigger also starts a conversion when converter enabled.
// - Unit three and plain units treat trigger mode as software flag mode.
// - Unit two trigger clears timer without raising that timer's flag.
// - Four outputs with selectable polarity; config bits 7:6, mode bits 3:0.
// - PWM controls double-buffered, loaded only at period boundary, except dead-band delay.
// - Dead-band copy loads at duty boundary or period boundary, earliest.
// - PWM starts only after its timer resets, one cycle late.
// - Period is (limit plus one) times four clocks times prescale.
// - At limit match timer clears, output sets unless zero duty, duty copied.
// - Postscaler has no effect on PWM frequency.
// - Duty is ten bits: eight upper bits plus control bits 5:4.
// - Duty writes any time; copied at period match; buffer read-only.
// - Output clears when duty buffer equals timer with two fine bits.
// - Duty beyond period keeps output set all cycle.
// - Config 00 single, 10 half, 01 full forward, 11 full reverse.
// - Unit three quad mode overrides plain unit pin with output D.
// - Half-bridge drives PWM on A and complement on B.
// - Forward: A active, D modulated. Reverse: C active, B modulated.
// - Dead-band delays inactive-to-active edges; too long stays inactive.
// - Relocated outside microcontroller mode, units one and three single only.
`timescale 1ns/100ps
`include "ecp_defs.svh"
module ecp_top #(
   parameter int unsigned UNIT_ID = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] pwm_control_reg_i,
   input wire logic [7:0] duty_upper_write_reg_i,
   input wire logic [7:0] period_limit_reg_i,
   input wire logic [7:0] period_limit_alt_i,
   input wire logic [1:0] pwm_prescale_select_i,
   input wire logic [1:0] alt_prescale_select_i,
   input wire logic timer_select_control_i,
   input wire logic [6:0] deadband_delay_reg_i,
   input wire logic [15:0] compare_reg_i,
   input wire logic [15:0] first_compare_time_base_i,
   input wire logic [15:0] second_compare_time_base_i,
   input wire logic compare_timer_sel_i,
   input wire logic adc_enable_i,
   input wire logic output_relocate_select_i,
   input wire logic micro_mode_i,
   input wire logic plain_unit_pin_i,
   output logic output_a_o,
   output logic output_b_o,
   output logic output_c_o,
   output logic output_d_o,
   output logic plain_pin_o,
   output logic compare_flag_o,
   output logic clear_first_o,
   output logic clear_second_o,
   output logic adc_start_o,
   output logic [9:0] duty_shadow_buffer_o
);
   ecp_pkg::ecp_top_state_t s;
   ecp_pkg::ecp_top_state_t next_s;
   ecp_tb_if tbs[2] ();
   ecp_db_if db ();
   logic [3:0] mode;
   logic is_pwm;
   logic single_only;
   logic trig_unit;
   logic sel_ps;
   logic [9:0] sel_count;
   logic [9:0] duty_in;
   logic [1:0] cfg_in;
   logic [15:0] cmp_base;
   logic cmp_match;
   logic cmp_hit;
   logic cmp_trig;
   logic duty_edge;
   logic [3:0] pol_mask;

   function automatic logic [3:0] drive_map(
      input logic [1:0] cfg,
      input logic mod_a,
      input logic mod_b
   );
      case (cfg)
         `ECP_CFG_SINGLE: drive_map = {3'h0, mod_a};
         `ECP_CFG_HALF: drive_map = {2'h0, mod_b, mod_a};
         `ECP_CFG_FWD: drive_map = {mod_a, 2'h0, 1'b1};
         default: drive_map = {1'b0, 1'b1, mod_a, 1'b0};
      endcase
   endfunction: drive_map

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_tb
         ecp_timebase u_tb (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tb(tbs[g])
         );
      end
   endgenerate

   ecp_deadband u_db (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .db(db)
   );

   assign tbs[0].period = period_limit_reg_i;
   assign tbs[0].prescale = pwm_prescale_select_i;
   assign tbs[1].period = period_limit_alt_i;
   assign tbs[1].prescale = alt_prescale_select_i;

   // PWM time base is one of two timers
   assign sel_ps = s.tsel ? tbs[1].period_start : tbs[0].period_start;
   assign sel_count = s.tsel ? {tbs[1].tmr, tbs[1].fine} : {tbs[0].tmr, tbs[0].fine};

   assign mode = pwm_control_reg_i[`ECP_MODE_MSB:`ECP_MODE_LSB];
   assign is_pwm = (mode[3:2] == `ECP_MODE_PWM);
   assign duty_in = {duty_upper_write_reg_i,
      pwm_control_reg_i[`ECP_DUTY_LO_MSB:`ECP_DUTY_LO_LSB]};
   // Pin straps are read only after the two-stage synchroniser
   assign single_only = (UNIT_ID == 1 || UNIT_ID == 3) && s.rs2[1] && !s.rs2[0];
   assign cfg_in = single_only ? `ECP_CFG_SINGLE :
      pwm_control_reg_i[`ECP_CFG_MSB:`ECP_CFG_LSB];
   assign pol_mask = {s.pol[0], s.pol[1], s.pol[0], s.pol[1]};

   // Compare time base is the first or second compare timer
   assign cmp_base = compare_timer_sel_i ? second_compare_time_base_i :
      first_compare_time_base_i;
   assign cmp_match = (cmp_base == compare_reg_i);
   // Edge only: the timer may sit on the value for many cycles
   assign cmp_hit = cmp_match && !s.match_prev && (mode[3:2] == `ECP_MODE_CMP) &&
      (s.st == ecp_pkg::st_idle);
   assign trig_unit = (UNIT_ID == 1 || UNIT_ID == 2);
   assign cmp_trig = cmp_hit && (mode == `ECP_MODE_TRIG) && trig_unit;

   // Duty boundary: the count reaches the buffered duty
   assign duty_edge = (s.st == ecp_pkg::st_run) && !sel_ps && (sel_count == s.duty);

   assign db.level = s.pwm_on;
   // Dead band only applies to half-bridge operation
   assign db.delay = (s.cfg == `ECP_CFG_HALF) ? s.dly : `ECP_RST_DELAY;

   always_comb
   begin
      next_s = s;
      next_s.rs1 = {output_relocate_select_i, micro_mode_i};
      next_s.rs2 = s.rs1;
      next_s.match_prev = cmp_match;
      // Both compare flavours raise the unit's own flag
      next_s.cmp_flag = cmp_hit;
      // Timer clear carries no timer flag; that flag lives elsewhere
      next_s.clr_first = cmp_trig && !compare_timer_sel_i;
      next_s.clr_second = cmp_trig && compare_timer_sel_i;
      next_s.adc_start = cmp_trig && (UNIT_ID == 2) && adc_enable_i;
      case (s.st)
         ecp_pkg::st_idle:
         begin
            next_s.pwm_on = 1'b0;
            next_s.outs = 4'h0;
            if (is_pwm)
            begin
               next_s.st = ecp_pkg::st_wait;
               next_s.tsel = timer_select_control_i;
               next_s.cfg = cfg_in;
               next_s.pol = mode[1:0];
            end
         end
         ecp_pkg::st_wait:
         begin
            next_s.pwm_on = 1'b0;
            next_s.outs = pol_mask;
            if (!is_pwm)
               next_s.st = ecp_pkg::st_idle;
            else if (sel_ps)
            begin
               // Waiting for the reset costs up to one PWM period
               next_s.st = ecp_pkg::st_run;
               next_s.cfg = cfg_in;
               next_s.pol = mode[1:0];
               next_s.duty = duty_in;
               next_s.dly = deadband_delay_reg_i;
               next_s.pwm_on = (duty_in != `ECP_RST_DUTY);
            end
         end
         ecp_pkg::st_run:
         begin
            next_s.outs = drive_map(s.cfg, db.out_a, db.out_b) ^ pol_mask;
            if (!is_pwm)
            begin
               next_s.st = ecp_pkg::st_idle;
               next_s.pwm_on = 1'b0;
            end
            else if (sel_ps)
            begin
               // Working copies except the dead-band delay change only here, so no glitch
               next_s.tsel = timer_select_control_i;
               next_s.cfg = cfg_in;
               next_s.pol = mode[1:0];
               next_s.duty = duty_in;
               next_s.dly = deadband_delay_reg_i;
               next_s.pwm_on = (duty_in != `ECP_RST_DUTY);
            end
            else if (duty_edge)
            begin
               // Duty past the period never matches, so stays set
               next_s.pwm_on = 1'b0;
               next_s.dly = deadband_delay_reg_i;
            end
         end
         default:
         begin
            next_s.st = ecp_pkg::st_idle;
            next_s.pwm_on = 1'b0;
            next_s.outs = 4'h0;
         end
      endcase
      // Quad mode on unit three takes the plain unit's pin
      if ((UNIT_ID == 3) && (s.st != ecp_pkg::st_idle) && is_pwm && s.cfg[0])
         next_s.plain_pin = next_s.outs[3];
      else
         next_s.plain_pin = plain_unit_pin_i;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s <= '0;
         s.st <= ecp_pkg::st_idle;
      end
      else
         s <= next_s;
   end

   assign output_a_o = s.outs[0];
   assign output_b_o = s.outs[1];
   assign output_c_o = s.outs[2];
   assign output_d_o = s.outs[3];
   assign plain_pin_o = s.plain_pin;
   assign compare_flag_o = s.cmp_flag;
   assign clear_first_o = s.clr_first;
   assign clear_second_o = s.clr_second;
   assign adc_start_o = s.adc_start;
   // Read-only copy for software
   assign duty_shadow_buffer_o = s.duty;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence seq_trigger_hit;
      cmp_hit && (mode == `ECP_MODE_TRIG) && trig_unit;
   endsequence

   sequence seq_period_edge;
      (s.st == ecp_pkg::st_run) && sel_ps && is_pwm;
   endsequence

   sequence seq_wait_open;
      (s.st == ecp_pkg::st_wait) && !sel_ps;
   endsequence

   chk_trigger_on_match: assert property (
      seq_trigger_hit |=> (clear_first_o || clear_second_o)
   ) else $error("trigger missing after compare match");

   chk_clear_follows_sel: assert property (
      clear_first_o |-> !$past(compare_timer_sel_i) && !clear_second_o
   ) else $error("wrong timer cleared by trigger");

   chk_adc_needs_enable: assert property (
      adc_start_o |-> (UNIT_ID == 2) && $past(adc_enable_i) && (clear_first_o || clear_second_o)
   ) else $error("conversion start without enable or trigger");

   chk_no_trigger_unit: assert property (
      !trig_unit |-> !(clear_first_o || clear_second_o || adc_start_o)
   ) else $error("trigger raised on unit without trigger");

   chk_start_after_reset: assert property (
      seq_wait_open |=> (s.st != ecp_pkg::st_run)
   ) else $error("PWM started before timer reset");

   chk_period_loads_duty: assert property (
      seq_period_edge |=> (s.duty == $past(duty_in)) &&
         (s.pwm_on == ($past(duty_in) != `ECP_RST_DUTY))
   ) else $error("duty not copied or output not set at period");

   chk_duty_clears: assert property (
      duty_edge && is_pwm |=> !s.pwm_on ##1 !db.out_a
   ) else $error("output not cleared at duty match");

   chk_controls_buffered: assert property (
      (s.st == ecp_pkg::st_run) && !sel_ps |=> $stable(s.cfg) && $stable(s.pol) &&
         $stable(s.duty) && $stable(s.tsel)
   ) else $error("working copy changed inside a period");

   chk_idle_inactive: assert property (
      (s.st == ecp_pkg::st_idle) [*2] |-> (s.outs == 4'h0)
   ) else $error("outputs active while not in PWM mode");

   chk_forward_a_active: assert property (
      (s.st == ecp_pkg::st_run) && (s.cfg == `ECP_CFG_FWD) && !sel_ps |=>
         (output_a_o != s.pol[1]) && (output_b_o == s.pol[0])
   ) else $error("forward bridge outputs wrong");
endmodule: ecp_top

// ---- dv/ecp_switch_model.sv ----
`timescale 1ns/100ps
module ecp_switch_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic high_on_i,
   input wire logic low_on_i,
   output int overlap_o
);
   // Both switches on at once shorts the bridge supply
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         overlap_o <= 0;
      else if (high_on_i && low_on_i)
         overlap_o <= overlap_o + 1;
   end
endmodule: ecp_switch_model

// ---- dv/enhanced_ccp_pwm_unit_bench.sv ----
`timescale 1ns/100ps
module enhanced_ccp_pwm_unit_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] ctrl = 8'h00;
   logic [7:0] duty_hi = 8'h00;
   logic [7:0] lim = 8'h00;
   logic [7:0] lim_alt = 8'h00;
   logic [1:0] ps = 2'h0;
   logic [1:0] ps_alt = 2'h0;
   logic tsel = 1'b0;
   logic [6:0] dly = 7'h00;
   logic [15:0] cmp = 16'h0000;
   logic [15:0] tb1 = 16'h0000;
   logic [15:0] tb3 = 16'h0000;
   logic csel = 1'b0;
   logic adc_en = 1'b0;
   logic reloc = 1'b0;
   logic micro = 1'b1;
   logic plain_in = 1'b0;
   logic [3:0] p2;
   logic [3:0] p3;
   logic [3:0] ev2;
   logic [3:0] ev3;
   logic plain2;
   logic plain3;
   logic [9:0] shadow2;
   logic [9:0] shadow3;
   logic [5:0] obs;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int overlap;

   assign obs = {p3[1], plain3, p2[3], p2[2], p2[1], p2[0]};

   ecp_top #(.UNIT_ID(2)) ecp_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .pwm_control_reg_i(ctrl), .duty_upper_write_reg_i(duty_hi), .period_limit_reg_i(lim),
      .period_limit_alt_i(lim_alt), .pwm_prescale_select_i(ps), .alt_prescale_select_i(ps_alt),
      .timer_select_control_i(tsel), .deadband_delay_reg_i(dly), .compare_reg_i(cmp),
      .first_compare_time_base_i(tb1), .second_compare_time_base_i(tb3),
      .compare_timer_sel_i(csel), .adc_enable_i(adc_en), .output_relocate_select_i(reloc),
      .micro_mode_i(micro), .plain_unit_pin_i(plain_in), .output_a_o(p2[0]),
      .output_b_o(p2[1]), .output_c_o(p2[2]), .output_d_o(p2[3]), .plain_pin_o(plain2),
      .compare_flag_o(ev2[3]), .clear_first_o(ev2[2]), .clear_second_o(ev2[1]),
      .adc_start_o(ev2[0]), .duty_shadow_buffer_o(shadow2));

   // Unit three shares every input; it lacks triggers and owns the shared pin
   ecp_top #(.UNIT_ID(3)) ecp_top_inst3 (.clk_i(clk_i), .rst_i(rst_i),
      .pwm_control_reg_i(ctrl), .duty_upper_write_reg_i(duty_hi), .period_limit_reg_i(lim),
      .period_limit_alt_i(lim_alt), .pwm_prescale_select_i(ps), .alt_prescale_select_i(ps_alt),
      .timer_select_control_i(tsel), .deadband_delay_reg_i(dly), .compare_reg_i(cmp),
      .first_compare_time_base_i(tb1), .second_compare_time_base_i(tb3),
      .compare_timer_sel_i(csel), .adc_enable_i(adc_en), .output_relocate_select_i(reloc),
      .micro_mode_i(micro), .plain_unit_pin_i(plain_in), .output_a_o(p3[0]),
      .output_b_o(p3[1]), .output_c_o(p3[2]), .output_d_o(p3[3]), .plain_pin_o(plain3),
      .compare_flag_o(ev3[3]), .clear_first_o(ev3[2]), .clear_second_o(ev3[1]),
      .adc_start_o(ev3[0]), .duty_shadow_buffer_o(shadow3));

   ecp_switch_model ecp_switch_model_inst (.clk_i(clk_i), .rst_i(rst_i), .high_on_i(p2[0]),
      .low_on_i(p2[1]), .overlap_o(overlap));

   always #20 clk_i = ~clk_i;

   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask: results

   // Longest scenario is a few hundred cycles
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errors++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t ns: %s saw %0h expected %0h", $time, what, seen, exp);
      end
   endtask: check

   task automatic ticks(input int n);
      repeat (n) @(negedge clk_i);
   endtask: ticks

   task automatic step(inout int t);
      @(negedge clk_i);
      t++;
   endtask: step

   task automatic setup(input logic [7:0] c, input logic [9:0] d);
      @(negedge clk_i);
      ctrl = {c[7:6], d[1:0], c[3:0]};
      duty_hi = d[9:2];
   endtask: setup

   // Bounded waits: a dead pin yields values that cannot match
   task automatic measure(input int i, output int hi, output int per);
      int t;
      t = 0;
      hi = 0;
      per = 0;
      while (obs[i] !== 1'b0 && t < 400) step(t);
      while (obs[i] !== 1'b1 && t < 400) step(t);
      while (obs[i] === 1'b1 && hi < 400) step(hi);
      per = hi;
      while (obs[i] !== 1'b1 && per < 400) step(per);
   endtask: measure

   task automatic count_hi(input int i, input int n, output int hi);
      hi = 0;
      repeat (n)
      begin
         @(negedge clk_i);
         if (obs[i] === 1'b1)
            hi++;
      end
   endtask: count_hi

   task automatic t_reset();
      ticks(2);
      check(p2, 4'h0, "pins after reset");
      check(p3, 4'h0, "unit three pins after reset");
   endtask: t_reset

   task automatic t_compare();
      logic [3:0] e;
      for (int k = 0; k < 3; k++)
      begin
         setup((k == 2) ? 8'h0a : 8'h0b, 10'h000);
         csel = (k == 1);
         adc_en = (k != 1);
         cmp = 16'h1234;
         tb1 = 16'h0000;
         tb3 = 16'h0000;
         ticks(4);
         if (k == 1)
            tb3 = 16'h1234;
         else
            tb1 = 16'h1234;
         e = {1'b1, k == 0, k == 1, k == 0};
         ticks(1);
         check(ev2, e, "unit two events");
         check(ev3, 4'h8, "unit three events");
         ticks(1);
         check(ev2, 4'h0, "repeat equality");
      end
   endtask: t_compare

   task automatic t_single();
      int hi;
      int per;
      lim = 8'h04;
      setup(8'h0c, 10'd6);
      ticks(60);
      check(shadow2, 10'd6, "duty copy");
      measure(0, hi, per);
      check(hi, 6, "high time");
      check(per, 20, "period");
      setup(8'h0c, 10'd9);
      ticks(2);
      check(shadow2, 10'd6, "duty held mid period");
      measure(0, hi, per);
      check(hi, 9, "new duty at boundary");
      count_hi(1, 20, hi);
      check(hi, 0, "single leaves B idle");
      setup(8'h0c, 10'd0);
      ticks(50);
      count_hi(0, 40, hi);
      check(hi, 0, "zero duty");
      setup(8'h0c, 10'h3ff);
      ticks(50);
      count_hi(0, 40, hi);
      check(hi, 40, "duty over period");
   endtask: t_single

   task automatic t_timing();
      int hi;
      int per;
      ps = 2'h1;
      setup(8'h0c, 10'd6);
      ticks(200);
      measure(0, hi, per);
      check(hi, 24, "prescaled duty");
      check(per, 80, "prescaled period");
      ps = 2'h0;
      setup(8'h0f, 10'd6);
      ticks(60);
      measure(0, hi, per);
      check(hi, 14, "active low A");
      lim_alt = 8'h09;
      tsel = 1'b1;
      setup(8'h0c, 10'd6);
      ticks(120);
      measure(0, hi, per);
      check(per, 40, "alternate timer period");
      tsel = 1'b0;
   endtask: t_timing

   task automatic t_half();
      int hi;
      int per;
      int ov;
      setup(8'h8c, 10'd10);
      ticks(60);
      for (int k = 0; k < 20; k++)
      begin
         ticks(1);
         check(obs[1], !obs[0], "B complement");
      end
      dly = 7'h01;
      ticks(60);
      ov = overlap;
      measure(0, hi, per);
      check(hi, 6, "A after dead band");
      measure(1, hi, per);
      check(hi, 6, "B after dead band");
      check(overlap, ov, "no shoot-through");
      dly = 7'h05;
      ticks(60);
      count_hi(0, 40, hi);
      check(hi, 0, "dead band beyond duty");
      dly = 7'h00;
      reloc = 1'b1;
      micro = 1'b0;
      ticks(80);
      count_hi(5, 20, hi);
      check(hi, 0, "relocated unit three single");
      count_hi(1, 20, hi);
      check(hi, 10, "unit two keeps half");
      reloc = 1'b0;
      micro = 1'b1;
   endtask: t_half

   task automatic t_full();
      int hi;
      int per;
      int c;
      for (int k = 0; k < 2; k++)
      begin
         setup(k ? 8'hcc : 8'h4c, 10'd6);
         ticks(60);
         for (int i = 0; i < 4; i++)
         begin
            if (i != (k ? 1 : 3))
            begin
               count_hi(i, 20, c);
               check(c, (i == (k ? 2 : 0)) ? 20 : 0, "steady pin");
            end
         end
         measure(k ? 1 : 3, hi, per);
         check(hi, 6, "modulated pin");
      end
      setup(8'h4c, 10'd6);
      ticks(60);
      measure(4, hi, per);
      check(hi, 6, "shared pin carries D");
      setup(8'h0c, 10'd6);
      ticks(30);
      plain_in = 1'b1;
      ticks(1);
      check(plain3, 1'b1, "shared pin follows plain unit");
      plain_in = 1'b0;
      ticks(1);
      check(plain3, 1'b0, "shared pin follows plain unit");
   endtask: t_full

   initial
   begin
      ticks(20);
      rst_i = 1'b0;
      t_reset();
      t_compare();
      t_single();
      t_timing();
      t_half();
      t_full();
      results();
   end
endmodule: enhanced_ccp_pwm_unit_bench
